// ---- asf_pkg.sv ----
// Constants, command codes and mode type of the serial frame block
// ****************************************************************
// Behaviour
// [RQ1] Chip-select fall samples the selected channel and starts a conversion.
// [RQ2] First 16 clock cycles take SDI bits while SDO stays low.
// [RQ3] Conversion end loads 14-bit result MSB first with two low zeros.
// [RQ4] Sixteenth serial clock fall puts the shift register MSB on SDO.
// [RQ5] Each later fall shifts chain input in and drives next bit out.
// [RQ6] Host gives sixteen falls per chained converter; last converter arrives first.
// [RQ7] Chaining needs no setting; it comes from shifting the chain input.
// [RQ8] First chain input ties to ground, later ones to previous SDO.
// [RQ9] Chip-select rise puts SDO into high impedance.
// [RQ10] With shared SDO the host selects only one converter at once.
// [RQ11] After power-up the block idles with no conversion until a command.
// [RQ12] Registers take defaults at power-up; host configures before converting.
// [RQ13] All-zero word keeps the last mode and settings.
// [RQ14] All-zero word during register access keeps values, returns to idle.
// [RQ15] Command word completes on sixteenth fall; execution starts only then.
// [RQ16] Early chip-select rise enters invalid state until a proper command.
// [RQ17] In invalid state reads return data that is not valid.
// [RQ18] In invalid state threshold flag follows the previously selected channel.
// [RQ19] Settings received in a frame apply at the next chip-select fall.
// [RQ20] Codes 8200, 8300, A000 pick sleep, power-off, sweep at chip-select rise.
// [RQ21] Host places sixteenth fall after the conversion has finished.
// [RQ22] After the last data bit SDO drives zeros until the next conversion.
// [RQ23] Bit counter clears on chip-select fall, counts falls while selected.
// ****************************************************************
package asf_pkg;
    // Frame geometry
    localparam int          CMD_BITS      = 16;
    localparam int          RES_BITS      = 14;
    localparam int          SHIFT_BITS    = 16;
    localparam int          CNT_BITS      = 8;
    localparam logic [7:0]  CMD_LAST_EDGE = 8'h0F;
    localparam logic [7:0]  CNT_MAX       = 8'hFF;
    // Command codes
    localparam logic [15:0] CMD_CONTINUE  = 16'h0000;
    localparam logic [15:0] CMD_SLEEP     = 16'h8200;
    localparam logic [15:0] CMD_POWER_OFF = 16'h8300;
    localparam logic [15:0] CMD_AUTO      = 16'hA000;
    localparam logic [5:0]  CMD_MAN_TAG   = 6'b1100_00;
    localparam int          MAN_CH_LSB    = 7;
    // Reset values and result padding
    localparam logic [15:0] CMD_RST       = 16'h0000;
    localparam logic [15:0] SHIFT_RST     = 16'h0000;
    localparam logic [2:0]  CHAN_RST      = 3'h0;
    localparam logic [1:0]  RES_PAD       = 2'b00;
    // Modes
    typedef enum logic [2:0] {
        ASF_IDLE,
        ASF_LIGHT_SLEEP_MODE,
        ASF_FULL_POWER_OFF_MODE,
        ASF_AUTO_SWEEP,
        ASF_SINGLE_CHANNEL_SELECT,
        ASF_REGISTER_ACCESS_STATE,
        ASF_INVALID
    } asf_mode_t;
endpackage

// ---- asf_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module asf_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           rstn,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0]   async_i,
    output logic      [W-1:0]   sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // Two flops; first stage feeds only the second
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// ---- asf_frame.sv ----
// Serial frame logic: command capture, result shift, chain and modes
`timescale 1ns/1ps
module asf_frame #(
    parameter int NCH = 8
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    // Serial pins
    input  wire logic                         cs_n_i,
    input  wire logic                         sclk_i,
    input  wire logic                         sdi_i,
    input  wire logic                         daisy_i,
    output logic                              sdo_o,
    output logic                              sdo_oe,
    // Converter core
    output logic                              conv_start_o,
    output logic [2:0]                        conv_chan_o,
    input  wire logic                         conv_done_i,
    input  wire logic [asf_pkg::RES_BITS-1:0] conv_result_i,
    // Threshold flags
    input  wire logic [NCH-1:0]               alarm_i,
    output logic                              alarm_o,
    // Command and mode status
    output logic [asf_pkg::CMD_BITS-1:0]      cmd_word_o,
    output logic                              reg_cmd_o,
    output asf_pkg::asf_mode_t                mode_o
);
    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    logic [3:0] pins_s;
    logic       cs_n_s;
    logic       sclk_s;
    logic       sdi_s;
    logic       daisy_s;
    logic       cs_n_d_ff;
    logic       sclk_d_ff;

    asf_sync #(
        .W       (4),
        .RST_VAL (4'b1001)
    ) u_sync (
        .mclk    (mclk),
        .rstn    (rstn),
        .async_i ({cs_n_i, sclk_i, sdi_i, daisy_i}),
        .sync_o  (pins_s)
    );

    assign cs_n_s  = pins_s[3];
    assign sclk_s  = pins_s[2];
    assign sdi_s   = pins_s[1];
    assign daisy_s = pins_s[0];

    // Delayed copies for edge finding
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cs_n_d_ff <= 1'b1;
            sclk_d_ff <= 1'b0;
        end
        else
        begin
            cs_n_d_ff <= cs_n_s;
            sclk_d_ff <= sclk_s;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;

    assign cs_fall   = cs_n_d_ff & ~cs_n_s;
    assign cs_rise   = ~cs_n_d_ff & cs_n_s;
    assign sclk_fall = sclk_d_ff & ~sclk_s & ~cs_n_s;

    // ****************************************************************
    // State registers
    // ****************************************************************
    logic [asf_pkg::CNT_BITS-1:0]   cnt_ff;
    logic [asf_pkg::CMD_BITS-1:0]   cmd_ff;
    logic                           cmd_done_ff;
    logic [asf_pkg::SHIFT_BITS-1:0] shift_ff;
    logic                           sdo_ff;
    logic                           sdo_oe_ff;
    logic                           conv_start_ff;
    logic                           converting_ff;
    logic [2:0]                     chan_ff;
    logic [2:0]                     next_chan_ff;
    logic [2:0]                     seq_ff;
    logic                           alarm_ff;
    logic                           reg_cmd_ff;
    asf_pkg::asf_mode_t             mode_ff;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    logic       cmd_edge;
    logic       data_edge;
    logic       shift_edge;
    logic       data_bit;
    logic [2:0] man_chan;
    logic       is_man;
    logic       is_zero;
    logic       is_reg;
    logic       run_mode;
    logic [2:0] seq_last;
    logic [2:0] start_chan;
    logic [asf_pkg::CMD_BITS-1:0] cmd_full;

    // Edge class within the frame
    assign cmd_edge  = sclk_fall & (cnt_ff <= asf_pkg::CMD_LAST_EDGE);
    assign data_edge = sclk_fall & (cnt_ff >= asf_pkg::CMD_LAST_EDGE);
    // Chain bits enter only after the MSB fall, so the upstream MSB is caught
    assign shift_edge = sclk_fall & (cnt_ff > asf_pkg::CMD_LAST_EDGE);
    assign data_bit   = (cnt_ff == asf_pkg::CMD_LAST_EDGE) ? shift_ff[asf_pkg::SHIFT_BITS-1]
                                                          : shift_ff[asf_pkg::SHIFT_BITS-2];
    assign cmd_full  = {cmd_ff[asf_pkg::CMD_BITS-2:0], sdi_s};

    // Command word classes
    assign man_chan = cmd_ff[asf_pkg::MAN_CH_LSB +: 3];
    assign is_man   = (cmd_ff[15:10] == asf_pkg::CMD_MAN_TAG) && (man_chan < NCH);
    assign is_zero  = (cmd_ff == asf_pkg::CMD_CONTINUE);
    assign is_reg   = ~cmd_full[asf_pkg::CMD_BITS-1] && (cmd_full != asf_pkg::CMD_CONTINUE);

    // Conversion modes and channel picked at chip-select fall
    assign run_mode   = (mode_ff == asf_pkg::ASF_AUTO_SWEEP)
                      | (mode_ff == asf_pkg::ASF_SINGLE_CHANNEL_SELECT);  // RQ11
    assign seq_last   = 3'(NCH - 1);
    assign start_chan = (mode_ff == asf_pkg::ASF_AUTO_SWEEP) ? seq_ff : next_chan_ff;

    // ****************************************************************
    // Frame counter and command capture
    // ****************************************************************
    // Count falls of the serial clock, cleared at frame start
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            cnt_ff <= '0;
        else if (cs_fall)
            cnt_ff <= '0;                                                 // RQ23
        else if (sclk_fall && cnt_ff != asf_pkg::CNT_MAX)
            cnt_ff <= cnt_ff + 8'h01;                                     // RQ23
    end

    // Command word shifts in over the first sixteen falls
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cmd_ff      <= asf_pkg::CMD_RST;
            cmd_done_ff <= 1'b0;
        end
        else if (cs_fall)
            cmd_done_ff <= 1'b0;
        else if (cmd_edge)
        begin
            cmd_ff      <= cmd_full;                                      // RQ2
            cmd_done_ff <= (cnt_ff == asf_pkg::CMD_LAST_EDGE);            // RQ15
        end
    end

    // Register access command pulse after the last command bit
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            reg_cmd_ff <= 1'b0;
        else
            reg_cmd_ff <= cmd_edge && (cnt_ff == asf_pkg::CMD_LAST_EDGE) && is_reg; // RQ15
    end

    // ****************************************************************
    // Mode machine, applied at chip-select rise
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            mode_ff      <= asf_pkg::ASF_IDLE;                            // RQ11
            next_chan_ff <= asf_pkg::CHAN_RST;                            // RQ12
        end
        else if (cs_rise)
        begin
            if (!cmd_done_ff)
                mode_ff <= asf_pkg::ASF_INVALID;                          // RQ16
            else if (is_zero)
            begin
                case (mode_ff)
                    asf_pkg::ASF_REGISTER_ACCESS_STATE: mode_ff <= asf_pkg::ASF_IDLE; // RQ14
                    default:                            mode_ff <= mode_ff;           // RQ13
                endcase
            end
            else if (cmd_ff == asf_pkg::CMD_SLEEP)
                mode_ff <= asf_pkg::ASF_LIGHT_SLEEP_MODE;                 // RQ20
            else if (cmd_ff == asf_pkg::CMD_POWER_OFF)
                mode_ff <= asf_pkg::ASF_FULL_POWER_OFF_MODE;              // RQ20
            else if (cmd_ff == asf_pkg::CMD_AUTO)
                mode_ff <= asf_pkg::ASF_AUTO_SWEEP;                       // RQ20
            else if (is_man)
            begin
                mode_ff      <= asf_pkg::ASF_SINGLE_CHANNEL_SELECT;
                next_chan_ff <= man_chan;                                 // RQ19
            end
            else if (!cmd_ff[asf_pkg::CMD_BITS-1])
                mode_ff <= asf_pkg::ASF_REGISTER_ACCESS_STATE;
        end
    end

    // Sweep position; restarts on every sweep command
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            seq_ff <= asf_pkg::CHAN_RST;
        else if (cs_rise && cmd_done_ff && cmd_ff == asf_pkg::CMD_AUTO)
            seq_ff <= asf_pkg::CHAN_RST;                                  // RQ20
        else if (cs_fall && mode_ff == asf_pkg::ASF_AUTO_SWEEP)
            seq_ff <= (seq_ff == seq_last) ? asf_pkg::CHAN_RST : seq_ff + 3'h1;
    end

    // ****************************************************************
    // Conversion start and channel
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            conv_start_ff <= 1'b0;
            converting_ff <= 1'b0;
            chan_ff       <= asf_pkg::CHAN_RST;
        end
        else
        begin
            conv_start_ff <= cs_fall & run_mode;                          // RQ1
            if (cs_fall)
                converting_ff <= run_mode;
            else if (conv_done_i)
                converting_ff <= 1'b0;
            if (cs_fall && run_mode)
                chan_ff <= start_chan;                                    // RQ19
        end
    end

    // ****************************************************************
    // Output shift register and SDO
    // ****************************************************************
    // Chain input enters behind the result; zeros follow for a lone part
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            shift_ff <= asf_pkg::SHIFT_RST;
        else if (cs_fall)
            shift_ff <= asf_pkg::SHIFT_RST;                               // RQ17
        else if (conv_done_i && converting_ff)
            shift_ff <= {conv_result_i, asf_pkg::RES_PAD};                // RQ3
        else if (shift_edge)
            shift_ff <= {shift_ff[asf_pkg::SHIFT_BITS-2:0], daisy_s};     // RQ5 RQ7 RQ22
    end

    // SDO low during command phase, then MSB from the sixteenth fall
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end
        else
        begin
            sdo_oe_ff <= ~cs_n_s;                                         // RQ9
            if (cs_fall)
                sdo_ff <= 1'b0;                                           // RQ2
            else if (data_edge)
                sdo_ff <= data_bit;                                       // RQ4 RQ5
        end
    end

    // ****************************************************************
    // Threshold flag
    // ****************************************************************
    // Follows the last sampled channel, which stays unchanged while invalid
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            alarm_ff <= 1'b0;
        else
            alarm_ff <= alarm_i[chan_ff];                                 // RQ18
    end

    // Outputs
    assign sdo_o        = sdo_ff;
    assign sdo_oe       = sdo_oe_ff;
    assign conv_start_o = conv_start_ff;
    assign conv_chan_o  = chan_ff;
    assign alarm_o      = alarm_ff;
    assign cmd_word_o   = cmd_ff;
    assign reg_cmd_o    = reg_cmd_ff;
    assign mode_o       = mode_ff;
endmodule

// ---- asf_frame_checker.sv ----
// Assertion checker watching the serial frame block at its ports
`timescale 1ns/1ps
module asf_frame_checker #(
    parameter int NCH = 8
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rstn,
    // Serial pins
    input wire logic               cs_n_i,
    input wire logic               sclk_i,
    input wire logic               sdi_i,
    input wire logic               daisy_i,
    input wire logic               sdo_o,
    input wire logic               sdo_oe,
    // Converter core and flags
    input wire logic               conv_start_o,
    input wire logic [2:0]         conv_chan_o,
    input wire logic               conv_done_i,
    input wire logic [13:0]        conv_result_i,
    input wire logic [NCH-1:0]     alarm_i,
    input wire logic               alarm_o,
    // Command and mode
    input wire logic [15:0]        cmd_word_o,
    input wire logic               reg_cmd_o,
    input wire asf_pkg::asf_mode_t mode_o
);
    // ****************************************
    // Properties
    // ****************************************
    wire run_mode = mode_o == asf_pkg::ASF_AUTO_SWEEP
                 || mode_o == asf_pkg::ASF_SINGLE_CHANNEL_SELECT;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    a_oe_on_select: assert property ($fell(cs_n_i) |-> ##[2:4] sdo_oe)
        else $error("output not enabled after select");
    a_oe_off_release: assert property ($rose(cs_n_i) |-> ##[2:4] !sdo_oe)
        else $error("output still driven after release");
    a_quiet_command: assert property ($rose(sdo_oe) |-> (!sdo_o) [*8])
        else $error("data line not low during command bits");
    a_start_in_run: assert property ($fell(cs_n_i) && run_mode |-> ##[2:5] conv_start_o)
        else $error("no conversion start at select");
    a_no_idle_start: assert property (conv_start_o |-> run_mode)
        else $error("conversion started outside run modes");
    a_mode_at_rise: assert property ($changed(mode_o) |-> ##[0:2] !sdo_oe)
        else $error("mode changed inside a frame");
    a_invalid_quiet: assert property (mode_o == asf_pkg::ASF_INVALID |-> !sdo_o)
        else $error("data driven in invalid state");
    a_alarm_follows: assert property ($past(rstn) |-> alarm_o == $past(alarm_i[conv_chan_o]))
        else $error("threshold flag not from converted channel");
    a_reg_cmd_word: assert property (reg_cmd_o |-> !cmd_word_o[15] && cmd_word_o != 16'h0000)
        else $error("register access flagged for wrong word");
    c_invalid: cover property (mode_o == asf_pkg::ASF_INVALID);
    c_reg_cmd: cover property (reg_cmd_o);
    c_single: cover property (conv_start_o && mode_o == asf_pkg::ASF_SINGLE_CHANNEL_SELECT);
endmodule

bind asf_frame asf_frame_checker #(.NCH(NCH)) chk_u (
    .mclk          (mclk),
    .rstn          (rstn),
    .cs_n_i        (cs_n_i),
    .sclk_i        (sclk_i),
    .sdi_i         (sdi_i),
    .daisy_i       (daisy_i),
    .sdo_o         (sdo_o),
    .sdo_oe        (sdo_oe),
    .conv_start_o  (conv_start_o),
    .conv_chan_o   (conv_chan_o),
    .conv_done_i   (conv_done_i),
    .conv_result_i (conv_result_i),
    .alarm_i       (alarm_i),
    .alarm_o       (alarm_o),
    .cmd_word_o    (cmd_word_o),
    .reg_cmd_o     (reg_cmd_o),
    .mode_o        (mode_o)
);

// ---- asf_host_model.sv ----
// Serial master model that runs frames into the converter frame logic
`timescale 1ns/1ps
module asf_host_model (
    // Clock
    input  wire logic mclk,
    // Serial lines
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    output logic      daisy,
    input  wire logic sdo
);
    // ****************************************
    // Frame driver
    // ****************************************
    // Deselected, clock still and high, chain input grounded
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
        daisy = 1'b0;
    end
    // Command in, nf falls, up stands for an upstream converter's word
    task automatic frame(input logic [15:0] cmd, input int nf, input logic [15:0] up,
                         output logic [63:0] rx);
        rx = '0;
        @(posedge mclk) cs_n <= 1'b0;
        for (int k = 1; k <= nf; k++)
        begin
            sdi <= k <= 16 ? cmd[16-k] : 1'b0;
            repeat (15) @(posedge mclk);
            sclk <= 1'b0;
            repeat (4) @(posedge mclk);
            daisy <= (k >= 16 && k <= 31) ? up[31-k] : 1'b0;
            repeat (12) @(posedge mclk);
            sclk <= 1'b1;
            if (k >= 16) rx = {rx[62:0], sdo};
        end
        repeat (16) @(posedge mclk);
        cs_n <= 1'b1;
        repeat (40) @(posedge mclk);
    endtask
endmodule

// ---- asf_frame_tb.sv ----
// Self-checking testbench for the serial frame block
`timescale 1ns/1ps
module asf_frame_tb;
    // ****************************************
    // Bench
    // ****************************************
    logic               rstn, cs_n, sclk, sdi, daisy, sdo_w;
    logic               mclk = 1'b0;
    logic               tog = 1'b0;
    logic               conv_done_i = 1'b0;
    logic               sdo_o, sdo_oe, conv_start_o, alarm_o, reg_cmd_o;
    logic [2:0]         conv_chan_o, seq, sel, ch;
    logic [13:0]        conv_result_i;
    logic [7:0]         alarm_i = '0;
    logic [15:0]        cmd_word_o, cmd;
    asf_pkg::asf_mode_t mode_o;
    int                 fails, n_compared, pick;
    int                 wait_n = 0;
    int                 n_reg = 0;
    logic               single;

    always #2 mclk = ~mclk;
    // Shared data line: undriven it shows a changing pattern
    assign sdo_w = sdo_oe === 1'b1 ? sdo_o : tog;

    asf_frame #(.NCH(8)) dut_u (.mclk(mclk), .rstn(rstn), .cs_n_i(cs_n), .sclk_i(sclk),
        .sdi_i(sdi), .daisy_i(daisy), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i), .alarm_i(alarm_i), .alarm_o(alarm_o),
        .cmd_word_o(cmd_word_o), .reg_cmd_o(reg_cmd_o), .mode_o(mode_o));
    asf_host_model host_u (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .daisy(daisy), .sdo(sdo_w));

    // Core model: done well before the sixteenth fall, random flags
    always @(posedge mclk)
    begin
        tog <= ~tog;
        n_reg <= n_reg + (reg_cmd_o === 1'b1 ? 1 : 0);
        alarm_i <= 8'($urandom);
        conv_done_i <= wait_n == 1;
        wait_n <= conv_start_o === 1'b1 ? 10 + $urandom % 300 : (wait_n > 0 ? wait_n - 1 : 0);
    end

    task automatic check(input string what, input logic [63:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Own result padded, then the upstream word, as the host collects it
    function automatic logic [63:0] exp_rx(input logic [13:0] res, input logic [15:0] up,
                                           input int nf);
        return {31'h0, res, 2'b00, up, 1'b0} >> (48 - nf);
    endfunction

    // One frame, then stream, channel, mode and release are compared
    task automatic run(input logic [15:0] c, input int nf, input logic [15:0] up,
                       input logic conv, input logic [2:0] ch_e, input asf_pkg::asf_mode_t m);
        logic [63:0] rx;
        logic [13:0] res;
        int          r0;
        res = 14'($urandom);
        r0 = n_reg;
        conv_result_i <= res;
        host_u.frame(c, nf, up, rx);
        check("stream", rx, exp_rx(conv ? res : 14'h0, up, nf));
        if (conv) check("chan", 64'(conv_chan_o), 64'(ch_e));
        check("mode", 64'(mode_o), 64'(m));
        check("drive", 64'(sdo_oe), 64'h0);
        if (nf >= 16) check("word", 64'(cmd_word_o), 64'(c));
        check("reg pulse", 64'(n_reg - r0), 64'(nf >= 16 && !c[15] && c != 16'h0));
    endtask

    initial
    begin
        void'($urandom(32'h0000_c3b6));
        fails = 0;
        n_compared = 0;
        rstn = 1'b0;
        conv_result_i = '0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        check("reset mode", 64'(mode_o), 64'(asf_pkg::ASF_IDLE));
        check("reset cmd", 64'(cmd_word_o), 64'h0);
        run(asf_pkg::CMD_CONTINUE, 32, 16'h0, 1'b0, 3'h0, asf_pkg::ASF_IDLE);
        // Low-power modes hold across continue words and give no data
        for (int i = 0; i < 2; i++)
        begin
            run(i ? asf_pkg::CMD_POWER_OFF : asf_pkg::CMD_SLEEP, 32, 16'h0, 1'b0, 3'h0,
                i ? asf_pkg::ASF_FULL_POWER_OFF_MODE : asf_pkg::ASF_LIGHT_SLEEP_MODE);
            run(asf_pkg::CMD_CONTINUE, 32, 16'h0, 1'b0, 3'h0, i ? asf_pkg::ASF_FULL_POWER_OFF_MODE
                : asf_pkg::ASF_LIGHT_SLEEP_MODE);
        end
        run(16'(1 + $urandom % 32767), 32, 16'h0, 1'b0, 3'h0,
            asf_pkg::ASF_REGISTER_ACCESS_STATE);
        run(asf_pkg::CMD_CONTINUE, 32, 16'h0, 1'b0, 3'h0, asf_pkg::ASF_IDLE);
        // Abort one fall short of a full command word
        run(asf_pkg::CMD_AUTO, 15, 16'h0, 1'b0, 3'h0, asf_pkg::ASF_INVALID);
        run(asf_pkg::CMD_CONTINUE, 32, 16'h0, 1'b0, 3'h0, asf_pkg::ASF_INVALID);
        run(asf_pkg::CMD_AUTO, 32, 16'h0, 1'b0, 3'h0, asf_pkg::ASF_AUTO_SWEEP);
        // Random sweep, single-channel and restart frames, all chained behind a random upstream word
        seq = 3'h0;
        sel = 3'h0;
        single = 1'b0;
        for (int n = 0; n < 14; n++)
        begin
            ch = single ? sel : seq;
            if (!single) seq = seq + 3'h1;
            pick = $urandom % 3;
            cmd = asf_pkg::CMD_CONTINUE;
            if (pick == 0)
            begin
                sel = 3'($urandom);
                single = 1'b1;
                cmd = {asf_pkg::CMD_MAN_TAG, sel, 7'h00};
            end
            else if (pick == 2)
            begin
                seq = 3'h0;
                single = 1'b0;
                cmd = asf_pkg::CMD_AUTO;
            end
            run(cmd, 32 + $urandom % 17, 16'($urandom), 1'b1, ch, single ?
                asf_pkg::ASF_SINGLE_CHANNEL_SELECT : asf_pkg::ASF_AUTO_SWEEP);
        end
        give_verdict();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (90000) @(posedge mclk);
        fails++;
        give_verdict();
    end
endmodule
